// >>> core/ssa_pkg.sv
// Package of constants for sector sensing and addressing
package ssa_pkg;
  localparam int          SECTORS_PER_TRACK = 48;
  localparam logic [5:0]  SECTOR_LAST       = 6'h2F;
  localparam logic [8:0]  CYL_LAST          = 9'h19A;
  localparam logic [1:0]  HEAD_LAST         = 2'h3;
  localparam int          DATA_BYTES        = 256;
  localparam int          BYTE_BITS         = 8;
  // Sector address field layout: cyl[8:0], head[1:0], sector[5:0], flags[2:0]
  localparam int          AF_WIDTH          = 20;
  localparam int          AF_CYL_POS        = 11;
  localparam int          AF_HEAD_POS       = 9;
  localparam int          AF_SECT_POS       = 3;
  localparam int          AF_SPARE_POS      = 2;
  localparam int          AF_DEFECT_POS     = 1;
  localparam int          AF_PROT_POS       = 0;
  localparam logic [5:0]  SECTOR_RESET      = 6'h00;
  localparam logic [1:0]  REQ_IDLE          = 2'h1;
  localparam logic [1:0]  REQ_DONE          = 2'h2;
endpackage

// >>> core/ssa_sector_sense.sv
// Sector counters, address checks and sector field packing
`timescale 1ns/1ps
// Overview of operation
// - Track split into 48 servo-counted sectors
// - Separate fixed and removable sector counters
// - Count each boundary, clear on index
// - Sector zero located by index marks
// - Cylinder address valid 0 through 410
// - Head 0..3; cylinder, head, sector together
// - Address field carries CHS plus flags
// - Data field is 256 eight-bit bytes
// - Report current sector on controller request
// - Signals active level; inverted names complement

// Two-flop synchroniser and active-edge detector for one pin
module ssa_pin_edge #(
  parameter logic ACTIVE_HIGH = 1'h1
) (
  // Clock and reset
  input  wire  logic mclk,
  input  wire  logic rst_n,
  // Asynchronous pin
  input  wire  logic pinRaw,
  // One-cycle pulse on the active edge
  output logic       edgeSeen
);

  typedef struct packed {
    logic [1:0] sync;
    logic       prev;
  } ssa_edge_s;

  // Idle level at reset, so release gives no false edge
  localparam ssa_edge_s EDGE_RESET = '{sync: {2{~ACTIVE_HIGH}}, prev: 1'h0};

  ssa_edge_s st;
  ssa_edge_s next_st;

  logic      active;

  always_comb begin
    next_st      = st;
    next_st.sync = {st.sync[0], pinRaw};
    // Only the second flop feeds logic
    active       = ACTIVE_HIGH ? st.sync[1] : ~st.sync[1];
    next_st.prev = active;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= EDGE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Pulse stands one cycle per active edge
  assign edgeSeen = active & ~st.prev;

endmodule

// Sector counter: steps on each boundary, clears on index
module ssa_sect_counter
  import ssa_pkg::*;
#(
  parameter int WIDTH   = $bits(SECTOR_LAST),
  parameter int SECTORS = SECTORS_PER_TRACK
) (
  // Clock and reset
  input  wire  logic             mclk,
  input  wire  logic             rst_n,
  // Boundary and index events
  input  wire  logic             stepEdge,
  input  wire  logic             clearEdge,
  // Sector under the heads
  output logic [WIDTH-1:0]       count
);

  // Every sector number must fit the counter
  if (SECTORS < 2 || SECTORS > (1 << WIDTH)) begin : g_bad_count
    $error("ssa_sect_counter: sector count does not fit width");
  end

  localparam logic [WIDTH-1:0] CNT_ZERO = WIDTH'(SECTOR_RESET);
  localparam logic [WIDTH-1:0] CNT_ONE  = WIDTH'(1);
  localparam logic [WIDTH-1:0] CNT_LAST = WIDTH'(SECTORS - 1);

  typedef struct packed {
    logic [WIDTH-1:0] cnt;
  } ssa_count_s;

  ssa_count_s st;
  ssa_count_s next_st;

  always_comb begin
    next_st = st;
    // clear on index, else count
    // Index beats a boundary in the same cycle
    if (clearEdge) begin
      next_st.cnt = CNT_ZERO;
    end else if (stepEdge) begin
      next_st.cnt = (st.cnt == CNT_LAST) ? CNT_ZERO : st.cnt + CNT_ONE;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{cnt: CNT_ZERO};
    end else begin
      st <= next_st;
    end
  end

  assign count = st.cnt;

endmodule

module ssa_sector_sense
  import ssa_pkg::*;
#(
  parameter int SECTORS = SECTORS_PER_TRACK
) (
  // Clock and reset
  input  wire  logic                mclk,
  input  wire  logic                rst_n,
  // Servo and index pins, asynchronous
  input  wire  logic                servoSectorPulse,
  input  wire  logic                fixedIndexMark,
  input  wire  logic                removableIndex_n,
  // Controller sector request
  input  wire  logic                idReq,
  input  wire  logic                idSelRemovable,
  output logic                      idAck,
  output logic [5:0]                idSector,
  // Address to check and pack
  input  wire  logic [8:0]          reqCyl,
  input  wire  logic [1:0]          reqHead,
  input  wire  logic [5:0]          reqSector,
  input  wire  logic                reqSpare,
  input  wire  logic                reqDefective,
  input  wire  logic                reqProtected,
  output logic                      addrValid,
  output logic                      addrIllegal_n,
  output logic [AF_WIDTH-1:0]       addrField,
  // Data field size for the data path
  output logic [8:0]                dataFieldBytes,
  // Live counts
  output logic [5:0]                fixedSector,
  output logic [5:0]                removableSector,
  output logic                      sectorTick
);

  // Address checks assume the documented sector count
  if (SECTORS != SECTORS_PER_TRACK) begin : g_bad_sectors
    $error("ssa_sector_sense: only 48 sectors per track supported");
  end

  // Field widths follow the largest legal values
  localparam int CYL_W  = $bits(CYL_LAST);
  localparam int HEAD_W = $bits(HEAD_LAST);
  localparam int SECT_W = $bits(SECTOR_LAST);

  // Packed field must hold the address and three flags
  if (AF_WIDTH != CYL_W + HEAD_W + SECT_W + 3) begin : g_bad_field
    $error("ssa_sector_sense: address field width mismatch");
  end

  typedef enum logic [1:0] {
    REQ_WAIT = REQ_IDLE,
    REQ_ACK  = REQ_DONE
  } ssa_req_e;

  typedef struct packed {
    logic                tick;
    ssa_req_e            req;
    logic [5:0]          idSector;
    logic                valid;
    logic [AF_WIDTH-1:0] field;
  } ssa_state_s;

  ssa_state_s st;
  ssa_state_s next_st;

  logic secEdge;
  logic fixEdge;
  logic remEdge;
  logic inRange;
  logic [5:0] fixCnt;
  logic [5:0] remCnt;

  ssa_pin_edge #(
    .ACTIVE_HIGH (1'h1)
  ) u_secPin (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .pinRaw   (servoSectorPulse),
    .edgeSeen (secEdge)
  );

  ssa_pin_edge #(
    .ACTIVE_HIGH (1'h1)
  ) u_fixPin (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .pinRaw   (fixedIndexMark),
    .edgeSeen (fixEdge)
  );

  ssa_pin_edge #(
    .ACTIVE_HIGH (1'h0)
  ) u_remPin (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .pinRaw   (removableIndex_n),
    .edgeSeen (remEdge)
  );

  ssa_sect_counter #(
    .SECTORS (SECTORS)
  ) u_fixCount (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .stepEdge  (secEdge),
    .clearEdge (fixEdge),
    .count     (fixCnt)
  );

  ssa_sect_counter #(
    .SECTORS (SECTORS)
  ) u_remCount (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .stepEdge  (secEdge),
    .clearEdge (remEdge),
    .count     (remCnt)
  );

  always_comb begin
    next_st = st;
    // Tick marks the cycle the counters move
    next_st.tick = secEdge;
    case (st.req)
      REQ_WAIT: begin
        if (idReq) begin
          next_st.idSector = idSelRemovable ? remCnt : fixCnt;
          next_st.req      = REQ_ACK;
        end
      end
      REQ_ACK: begin
        if (!idReq) begin
          next_st.req = REQ_WAIT;
        end
      end
      default: begin
        next_st.req = REQ_WAIT;
      end
    endcase
    // cylinder, head and sector range, all three
    inRange = (reqCyl <= CYL_LAST) && (reqHead <= HEAD_LAST) && (reqSector <= SECTOR_LAST);
    next_st.valid = inRange;
    next_st.field = '0;
    next_st.field[AF_CYL_POS +: CYL_W]   = reqCyl;
    next_st.field[AF_HEAD_POS +: HEAD_W] = reqHead;
    next_st.field[AF_SECT_POS +: SECT_W] = reqSector;
    next_st.field[AF_SPARE_POS]     = reqSpare;
    next_st.field[AF_DEFECT_POS]    = reqDefective;
    next_st.field[AF_PROT_POS]      = reqProtected;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st     <= '0;
      st.req <= REQ_WAIT;
    end else begin
      st <= next_st;
    end
  end

  assign idAck           = (st.req == REQ_ACK);
  assign idSector        = st.idSector;
  assign addrValid       = st.valid;
  assign addrIllegal_n   = st.valid;
  assign addrField       = st.field;
  assign dataFieldBytes  = 9'(DATA_BYTES);
  assign fixedSector     = fixCnt;
  assign removableSector = remCnt;
  assign sectorTick      = st.tick;

endmodule

// >>> tb/ssa_monitor.sv
// Checker for sector sensing and addressing
`timescale 1ns/1ps
module ssa_monitor
  import ssa_pkg::*;
(
  // Clock and reset
  input  wire  logic                mclk,
  input  wire  logic                rst_n,
  // Sector request
  input  wire  logic                idReq,
  input  wire  logic                idAck,
  input  wire  logic [5:0]          idSector,
  // Counters
  input  wire  logic                sectorTick,
  input  wire  logic [5:0]          fixedSector,
  input  wire  logic [5:0]          removableSector,
  // Address check
  input  wire  logic [8:0]          reqCyl,
  input  wire  logic [5:0]          reqSector,
  input  wire  logic                addrValid,
  input  wire  logic                addrIllegal_n,
  input  wire  logic [AF_WIDTH-1:0] addrField,
  input  wire  logic [8:0]          dataFieldBytes
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  a_addr_ok: assert property (rst_n && reqCyl <= CYL_LAST && reqSector <= SECTOR_LAST |=> addrValid)
    else $error("legal address refused");
  a_addr_bad: assert property (rst_n && (reqCyl > CYL_LAST || reqSector > SECTOR_LAST) |=> !addrValid)
    else $error("illegal address accepted");
  a_low_twin: assert property (addrIllegal_n == addrValid)
    else $error("low flag differs");
  a_field_cyl: assert property (rst_n |=> addrField[AF_CYL_POS +: 9] == $past(reqCyl))
    else $error("field cylinder wrong");
  a_data_size: assert property (dataFieldBytes == 9'h100)
    else $error("data size wrong");
  a_tick_inc: assert property (sectorTick && fixedSector != 0 |-> fixedSector == $past(fixedSector) + 6'h01)
    else $error("count not advanced");
  a_tick_wrap: assert property (sectorTick && $past(fixedSector) == SECTOR_LAST |-> fixedSector == 0)
    else $error("count not wrapped");
  a_rem_wrap: assert property (sectorTick && $past(removableSector) == SECTOR_LAST |-> removableSector == 0)
    else $error("removable count not wrapped");
  a_ack_rise: assert property (idReq && !idAck |=> idAck)
    else $error("no ack");
  a_ack_hold: assert property (idAck && idReq |=> idAck && $stable(idSector))
    else $error("ack not held");
endmodule
bind ssa_sector_sense ssa_monitor mon (
  .mclk            (mclk),
  .rst_n           (rst_n),
  .idReq           (idReq),
  .idAck           (idAck),
  .idSector        (idSector),
  .sectorTick      (sectorTick),
  .fixedSector     (fixedSector),
  .removableSector (removableSector),
  .reqCyl          (reqCyl),
  .reqSector       (reqSector),
  .addrValid       (addrValid),
  .addrIllegal_n   (addrIllegal_n),
  .addrField       (addrField),
  .dataFieldBytes  (dataFieldBytes)
);

// >>> tb/ssa_ctrl_model.sv
// Controller model asking for sector identity
`timescale 1ns/1ps
module ssa_ctrl_model (
  input wire logic       mclk,
  input wire logic       idAck,
  input wire logic [5:0] idSector,
  output logic           idReq = 0,
  output logic           idSelRemovable = 0
);
  task read_id(input logic s, output logic [5:0] v);
    @(posedge mclk);
    idReq <= 1;
    idSelRemovable <= s;
    do @(posedge mclk); while (idAck !== 1'b1);
    v = idSector;
    idReq <= 0;
    do @(posedge mclk); while (idAck !== 1'b0);
  endtask
endmodule

// >>> tb/tb_top.sv
// Testbench for sector sensing and addressing
`timescale 1ns/1ps
module tb_top;
  import ssa_pkg::*;
  logic mclk = 0, rst_n = 0, servo = 0, fIdx = 0, rIdx_n = 1, idReq, idSel, idAck, valid;
  logic [8:0] cyl = 0, bytes;
  logic [1:0] hd = 0;
  logic [2:0] flg = 0;
  logic [5:0] sec = 0, idSector, fSec, rSec;
  logic [19:0] field;
  int err_total = 0, check_count = 0, fe = 0, re = 0;
  ssa_sector_sense DUT (.mclk(mclk), .rst_n(rst_n), .servoSectorPulse(servo), .fixedIndexMark(fIdx),
    .removableIndex_n(rIdx_n), .idReq(idReq), .idSelRemovable(idSel), .idAck(idAck), .idSector(idSector),
    .reqCyl(cyl), .reqHead(hd), .reqSector(sec), .reqSpare(flg[2]), .reqDefective(flg[1]),
    .reqProtected(flg[0]), .addrValid(valid), .addrIllegal_n(), .addrField(field),
    .dataFieldBytes(bytes), .fixedSector(fSec), .removableSector(rSec), .sectorTick());
  ssa_ctrl_model P (.mclk(mclk), .idAck(idAck), .idSector(idSector), .idReq(idReq), .idSelRemovable(idSel));
  always #25 mclk = ~mclk;
  task cmp(string n, logic [19:0] e, logic [19:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("Error %s exp %h got %h", n, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task t_addr(logic [8:0] c, logic [1:0] h, logic [5:0] s, logic [2:0] f, logic v);
    @(posedge mclk);
    {cyl, hd, sec, flg} <= {c, h, s, f};
    repeat (2) @(posedge mclk);
    #1;
    cmp("valid", v, valid);
    cmp("field", {c, h, s, f}, field);
  endtask
  task t_reset;
    @(posedge mclk);
    rst_n <= 0;
    repeat (2) @(posedge mclk);
    #1;
    cmp("fixed reset", SECTOR_RESET, fSec);
    cmp("removable reset", SECTOR_RESET, rSec);
    cmp("ack reset", 0, idAck);
    @(posedge mclk);
    rst_n <= 1;
    fe = 0;
    re = 0;
  endtask
  task pulse(logic fi, logic ri);
    @(posedge mclk);
    {servo, fIdx, rIdx_n} <= {2'b11 & {1'b1, fi}, !ri};
    repeat (3) @(posedge mclk);
    {servo, fIdx, rIdx_n} <= 3'b001;
    repeat (3) @(posedge mclk);
    #1;
    fe = fi ? 0 : (fe + 1) % 48;
    re = ri ? 0 : (re + 1) % 48;
    cmp("fixed", fe, fSec);
    cmp("removable", re, rSec);
  endtask
  task t_id(logic s, int e);
    logic [5:0] v;
    P.read_id(s, v);
    cmp("id", e, v);
  endtask
  initial begin
    #100000 err_total++;
    test_done;
  end
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1;
    cmp("bytes", DATA_BYTES, bytes);
    t_addr(CYL_LAST, HEAD_LAST, SECTOR_LAST, 3'h4, 1);
    t_addr(9'h19B, 0, 0, 3'h2, 0);
    t_addr(0, 2'h2, 6'h30, 3'h1, 0);
    repeat (49) pulse(0, 0);
    t_id(0, fe);
    pulse(1, 0);
    pulse(0, 0);
    pulse(0, 1);
    t_id(1, re);
    t_id(0, fe);
    pulse(0, 0);
    t_reset;
    pulse(0, 0);
    t_id(1, re);
    test_done;
  end
endmodule
